// *** hw/pmfc_pkg.sv ***
// Package for the page-mode flash controller: command codes, timing counts, geometry.
// Assumes a 125 MHz REF_CLK; flash timing figures are given in ns.
package pmfc_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int T_RANDOM_NS   = 60;
	localparam int T_PAGE_NS     = 20;
	localparam int T_WRITE_NS    = 40;
	localparam int RANDOM_CYC    = (T_RANDOM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PAGE_CYC      = (T_PAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_CYC     = (T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ADDR_W        = 21;
	localparam int DATA_W        = 32;
	localparam int NARROW_WORDS  = 2097152;
	localparam int WIDE_WORDS    = 1048576;
	localparam int PAGE_NARROW   = 8;
	localparam int PAGE_WIDE     = 4;
	localparam int POLL_BIT      = 7;
	localparam int TOGGLE_BIT    = 6;
	localparam logic [ADDR_W-1:0] UNLOCK_A1 = 21'h000555;
	localparam logic [ADDR_W-1:0] UNLOCK_A2 = 21'h0002aa;
	localparam logic [7:0] UNLOCK_D1     = 8'haa;
	localparam logic [7:0] UNLOCK_D2     = 8'h55;
	localparam logic [7:0] CMD_PROGRAM   = 8'ha0;
	localparam logic [7:0] CMD_ERASE     = 8'h80;
	localparam logic [7:0] CMD_SECTOR_ER = 8'h30;
	localparam logic [7:0] CMD_CHIP_ER   = 8'h10;
	localparam logic [7:0] CMD_BYPASS    = 8'h20;
	localparam logic [7:0] CMD_BYP_EXIT1 = 8'h90;
	localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;
	localparam logic [7:0] CMD_SUSPEND   = 8'hb0;
	localparam logic [7:0] CMD_RESUME    = 8'h30;
	localparam logic [7:0] CMD_RESET     = 8'hf0;
	typedef enum logic [3:0] {
		OP_READ, OP_PROGRAM, OP_SECTOR_ERASE, OP_CHIP_ERASE, OP_SUSPEND,
		OP_RESUME, OP_BYPASS_ENTER, OP_BYPASS_EXIT, OP_RESET
	} pmfc_op_e;
endpackage

// *** hw/pmfc_bus_cycle.sv ***
// One asynchronous bus cycle on the flash pins: read or write, strobe held a fixed count.
// Assumes the flash answers within the counts of the package; no clock reaches the flash.
`timescale 1ns/1ps
`default_nettype none
module pmfc_bus_cycle
	import pmfc_pkg::*;
(
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          reset,
	// Request
	input  wire logic                          start,
	input  wire logic                          write,
	input  wire logic                          fast,
	input  wire logic [pmfc_pkg::ADDR_W-1:0]   addr,
	input  wire logic [pmfc_pkg::DATA_W-1:0]   wdata,
	output logic                               busy,
	output logic                               done,
	output logic [pmfc_pkg::DATA_W-1:0]        rdata,
	// Flash pins
	output logic [pmfc_pkg::ADDR_W-1:0]        f_addr,
	output logic                               f_ce_n,
	output logic                               f_oe_n,
	output logic                               f_we_n,
	output logic [pmfc_pkg::DATA_W-1:0]        f_dq_out,
	output logic                               f_dq_oe,
	input  wire logic [pmfc_pkg::DATA_W-1:0]   f_dq_in
);
	import pmfc_pkg::*;

	typedef enum logic [1:0] {IDLE, STROBE, RECOVER} pmfc_cyc_e;
	pmfc_cyc_e cyc, next_cyc;
	logic [3:0] cnt, next_cnt;
	logic [ADDR_W-1:0] next_f_addr;
	logic [DATA_W-1:0] next_rdata, next_dq_out;
	logic next_ce_n, next_oe_n, next_we_n, next_dq_oe, next_done;

	always_comb
	begin
		next_cyc = cyc;
		next_cnt = cnt;
		next_f_addr = f_addr;
		next_rdata = rdata;
		next_dq_out = f_dq_out;
		next_ce_n = f_ce_n;
		next_oe_n = f_oe_n;
		next_we_n = f_we_n;
		next_dq_oe = f_dq_oe;
		next_done = 1'b0;
		case (cyc)
			IDLE:
				if (start)
				begin
					// Separate strobes keep the data lines from fighting
					next_f_addr = addr;
					next_ce_n = 1'b0;
					next_oe_n = write;
					next_we_n = !write;
					next_dq_oe = write;
					next_dq_out = wdata;
					next_cnt = write ? 4'(WRITE_CYC) : (fast ? 4'(PAGE_CYC) : 4'(RANDOM_CYC));
					next_cyc = STROBE;
				end
			STROBE:
				if (cnt > 4'h1)
					next_cnt = cnt - 4'h1;
				else
				begin
					next_rdata = f_dq_in;
					next_oe_n = 1'b1;
					next_we_n = 1'b1;
					next_cyc = RECOVER;
				end
			RECOVER:
			begin
				// Chip select kept low: page hits need the device left selected
				next_dq_oe = 1'b0;
				next_done = 1'b1;
				next_cyc = IDLE;
			end
			default:
				next_cyc = IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cyc <= IDLE;
			cnt <= 4'h0;
			f_addr <= '0;
			rdata <= '0;
			f_dq_out <= '0;
			f_ce_n <= 1'b1;
			f_oe_n <= 1'b1;
			f_we_n <= 1'b1;
			f_dq_oe <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			cyc <= next_cyc;
			cnt <= next_cnt;
			f_addr <= next_f_addr;
			rdata <= next_rdata;
			f_dq_out <= next_dq_out;
			f_ce_n <= next_ce_n;
			f_oe_n <= next_oe_n;
			f_we_n <= next_we_n;
			f_dq_oe <= next_dq_oe;
			done <= next_done;
		end
	end

	assign busy = (cyc != IDLE);
endmodule // pmfc_bus_cycle
`default_nettype wire

// *** hw/pmfc_ctrl.sv ***
// Host-side controller for a page-mode NOR flash: reads, command sequences, status polling.
// Assumes a flash wired directly to the pins; user orders arrive on a plain request port.
//
// Summary of operation
// - Host drives width select: low for 16-bit words, high for 32-bit.
// - Busy device shows complement on bit 7, toggling bit 6; host polls.
// - Erase suspend allows reads and programs elsewhere; resume continues erase.
// - Host can place device in standby.
`timescale 1ns/1ps
`default_nettype none
module pmfc_ctrl
	import pmfc_pkg::*;
#(
	parameter int POLL_LIMIT = 65535
)
(
	// Clock and reset
	input  wire logic              REF_CLK,
	input  wire logic              RESET,
	// User request port
	input  wire logic              REQ_VALID,
	input  wire pmfc_pkg::pmfc_op_e REQ_OP,
	input  wire logic [pmfc_pkg::ADDR_W-1:0] REQ_ADDR,
	input  wire logic [pmfc_pkg::DATA_W-1:0] REQ_DATA,
	input  wire logic              WIDE_MODE,
	input  wire logic              STANDBY_REQ,
	output logic                   REQ_READY,
	output logic                   RSP_VALID,
	output logic [pmfc_pkg::DATA_W-1:0] RSP_DATA,
	output logic                   RSP_ERROR,
	output logic                   BYPASS_ACTIVE,
	output logic                   ERASE_SUSPENDED,
	// Flash pins
	output logic [pmfc_pkg::ADDR_W-1:0] FLASH_ADDR,
	output logic                   FLASH_CE_N,
	output logic                   FLASH_OE_N,
	output logic                   FLASH_WE_N,
	output logic                   FLASH_WORD_N,
	output logic [pmfc_pkg::DATA_W-1:0] FLASH_DQ_OUT,
	output logic                   FLASH_DQ_OE,
	input  wire logic [pmfc_pkg::DATA_W-1:0] FLASH_DQ_IN
);
	import pmfc_pkg::*;

	if (POLL_LIMIT < 1 || POLL_LIMIT > 65535)
		$error("POLL_LIMIT out of range");

	typedef enum logic [2:0] {ST_IDLE, ST_SEQ, ST_WAIT, ST_POLL, ST_RECOVER, ST_ANSWER} pmfc_st_e;
	pmfc_st_e st, next_st;
	pmfc_op_e op, next_op;
	logic [ADDR_W-1:0] addr, next_addr;
	logic [DATA_W-1:0] data, next_data, rsp_data, next_rsp_data;
	logic [2:0] step, next_step, nsteps;
	logic bypass, next_bypass, suspended, next_suspended;
	logic rsp_err, next_rsp_err, rsp_valid, next_rsp_valid;
	logic prev_toggle, next_prev_toggle, have_page, next_have_page;
	logic [ADDR_W-1:0] page_tag, next_page_tag;
	logic [15:0] polls, next_polls;
	logic cyc_start, cyc_write, cyc_fast, cyc_busy, cyc_done;
	logic [ADDR_W-1:0] cyc_addr;
	logic [DATA_W-1:0] cyc_wdata, cyc_rdata;
	logic ce_n_raw;

	// Address and data of the current write step in the command sequence
	always_comb
	begin
		cyc_addr = addr;
		cyc_wdata = '0;
		case (op)
			OP_PROGRAM:                     nsteps = bypass ? 3'd2 : 3'd4;
			OP_SECTOR_ERASE, OP_CHIP_ERASE: nsteps = 3'd6;
			OP_BYPASS_ENTER:                nsteps = 3'd3;
			OP_BYPASS_EXIT:                 nsteps = 3'd2;
			default:                        nsteps = 3'd1;
		endcase
		if (op == OP_SUSPEND || op == OP_RESUME || op == OP_RESET)
			cyc_wdata = {24'h0, op == OP_SUSPEND ? CMD_SUSPEND :
				(op == OP_RESUME ? CMD_RESUME : CMD_RESET)};
		else if (op == OP_BYPASS_EXIT)
			cyc_wdata = {24'h0, step == 3'd0 ? CMD_BYP_EXIT1 : CMD_BYP_EXIT2};
		else if (op == OP_PROGRAM && bypass)
		begin
			cyc_wdata = step == 3'd0 ? {24'h0, CMD_PROGRAM} : data;
			cyc_addr = step == 3'd0 ? UNLOCK_A1 : addr;
		end
		else if (op != OP_READ)
		begin
			// Unlock pairs at steps 0,1 and 3,4; command at 2; final write at last step
			cyc_addr = (step == 3'd1 || step == 3'd4) ? UNLOCK_A2 : UNLOCK_A1;
			cyc_wdata = {24'h0, (step == 3'd1 || step == 3'd4) ? UNLOCK_D2 : UNLOCK_D1};
			if (step == 3'd2)
				cyc_wdata = {24'h0, op == OP_PROGRAM ? CMD_PROGRAM :
					(op == OP_BYPASS_ENTER ? CMD_BYPASS : CMD_ERASE)};
			if (op == OP_PROGRAM && step == 3'd3)
			begin
				cyc_addr = addr;
				cyc_wdata = data;
			end
			if (step == 3'd5)
			begin
				cyc_addr = op == OP_CHIP_ERASE ? UNLOCK_A1 : addr;
				cyc_wdata = {24'h0, op == OP_CHIP_ERASE ? CMD_CHIP_ER : CMD_SECTOR_ER};
			end
		end
	end

	// Main sequencer
	always_comb
	begin
		next_st = st;
		next_op = op;
		next_addr = addr;
		next_data = data;
		next_step = step;
		next_bypass = bypass;
		next_suspended = suspended;
		next_rsp_err = rsp_err;
		next_rsp_data = rsp_data;
		next_rsp_valid = 1'b0;
		next_prev_toggle = prev_toggle;
		next_have_page = have_page && !(st == ST_IDLE && STANDBY_REQ);
		next_page_tag = page_tag;
		next_polls = polls;
		cyc_start = 1'b0;
		cyc_write = 1'b0;
		cyc_fast = 1'b0;
		case (st)
			ST_IDLE:
				if (REQ_VALID)
				begin
					next_op = REQ_OP;
					next_addr = REQ_ADDR;
					next_data = REQ_DATA;
					next_step = 3'd0;
					next_rsp_err = 1'b0;
					next_st = ST_SEQ;
				end
			ST_SEQ:
			begin
				cyc_start = 1'b1;
				cyc_write = (op != OP_READ);
				// Page hit only while the device stayed selected on the same page
				cyc_fast = have_page && page_tag == (WIDE_MODE ? {addr[ADDR_W-1:2], 2'b00} :
					{addr[ADDR_W-1:3], 3'b000});
				if (op != OP_READ)
					next_have_page = 1'b0;
				next_st = ST_WAIT;
			end
			ST_WAIT:
				if (cyc_done)
				begin
					if (op == OP_READ)
					begin
						next_rsp_data = cyc_rdata;
						next_have_page = 1'b1;
						next_page_tag = WIDE_MODE ? {addr[ADDR_W-1:2], 2'b00} :
							{addr[ADDR_W-1:3], 3'b000};
						next_st = ST_ANSWER;
					end
					else if (step + 3'd1 < nsteps)
					begin
						next_step = step + 3'd1;
						next_st = ST_SEQ;
					end
					else if (op == OP_PROGRAM || op == OP_SECTOR_ERASE ||
						op == OP_CHIP_ERASE || op == OP_RESUME)
					begin
						next_suspended = 1'b0;
						next_polls = '0;
						if (op != OP_PROGRAM)
							next_data = '1; // Erased cells read all ones
						next_op = OP_READ; // Status reads come from the same address
						next_step = 3'd7;
						next_st = ST_RECOVER;
					end
					else
					begin
						if (op == OP_BYPASS_ENTER)
							next_bypass = 1'b1;
						if (op == OP_BYPASS_EXIT || op == OP_RESET)
							next_bypass = 1'b0;
						if (op == OP_SUSPEND)
							next_suspended = 1'b1;
						next_st = ST_ANSWER;
					end
				end
			ST_RECOVER:
			begin
				// First status read primes the toggle reference
				cyc_start = 1'b1;
				next_st = ST_POLL;
			end
			ST_POLL:
				if (cyc_done)
				begin
					next_prev_toggle = cyc_rdata[TOGGLE_BIT];
					next_polls = polls + 16'h1;
					next_step = 3'd0;
					next_st = ST_RECOVER;
					if (step != 3'd7 && cyc_rdata[TOGGLE_BIT] == prev_toggle)
					begin
						// Toggle stopped: done, or refused sector left untouched
						next_rsp_err = (cyc_rdata[POLL_BIT] != data[POLL_BIT]) &&
							(data != '1);
						next_rsp_data = cyc_rdata;
						next_st = ST_ANSWER;
					end
					else if (polls == 16'(POLL_LIMIT))
					begin
						next_rsp_err = 1'b1;
						next_st = ST_ANSWER;
					end
				end
			ST_ANSWER:
			begin
				next_rsp_valid = 1'b1;
				next_st = ST_IDLE;
			end
			default:
				next_st = ST_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
		begin
			st <= ST_IDLE;
			op <= OP_READ;
			addr <= '0;
			data <= '0;
			step <= 3'd0;
			bypass <= 1'b0;
			suspended <= 1'b0;
			rsp_err <= 1'b0;
			rsp_data <= '0;
			rsp_valid <= 1'b0;
			prev_toggle <= 1'b0;
			have_page <= 1'b0;
			page_tag <= '0;
			polls <= '0;
		end
		else
		begin
			st <= next_st;
			op <= next_op;
			addr <= next_addr;
			data <= next_data;
			step <= next_step;
			bypass <= next_bypass;
			suspended <= next_suspended;
			rsp_err <= next_rsp_err;
			rsp_data <= next_rsp_data;
			rsp_valid <= next_rsp_valid;
			prev_toggle <= next_prev_toggle;
			have_page <= next_have_page;
			page_tag <= next_page_tag;
			polls <= next_polls;
		end
	end

	pmfc_bus_cycle u_cycle (.clk(REF_CLK), .reset(RESET), .start(cyc_start),
		.write(cyc_write), .fast(cyc_fast), .addr(cyc_addr), .wdata(cyc_wdata),
		.busy(cyc_busy), .done(cyc_done), .rdata(cyc_rdata), .f_addr(FLASH_ADDR),
		.f_ce_n(ce_n_raw), .f_oe_n(FLASH_OE_N), .f_we_n(FLASH_WE_N),
		.f_dq_out(FLASH_DQ_OUT), .f_dq_oe(FLASH_DQ_OE), .f_dq_in(FLASH_DQ_IN));

	// Standby only when idle; releasing chip select also loses the open page
	assign FLASH_CE_N = ce_n_raw || (STANDBY_REQ && st == ST_IDLE && !cyc_busy);
	assign FLASH_WORD_N = WIDE_MODE;
	assign REQ_READY = (st == ST_IDLE);
	assign RSP_VALID = rsp_valid;
	assign RSP_DATA = rsp_data;
	assign RSP_ERROR = rsp_err;
	assign BYPASS_ACTIVE = bypass;
	assign ERASE_SUSPENDED = suspended;
endmodule // pmfc_ctrl
`default_nettype wire

// *** tb/pmfc_ctrl_monitor.sv ***
// Checker bound to pmfc_ctrl: strobe discipline, write pulse, reset and answer timing.
// Sees only the controller's ports; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module pmfc_ctrl_monitor
(
	// Clock, reset, user side
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic REQ_VALID,
	input wire logic REQ_READY,
	input wire logic RSP_VALID,
	input wire logic WIDE_MODE,
	input wire logic STANDBY_REQ,
	// Flash pins
	input wire logic FLASH_CE_N,
	input wire logic FLASH_OE_N,
	input wire logic FLASH_WE_N,
	input wire logic FLASH_WORD_N,
	input wire logic FLASH_DQ_OE
);
	default clocking mon_cb @(posedge REF_CLK);
	endclocking
	default disable iff (RESET);
	chk_reset_idle: assert property (
		$fell(RESET) |-> FLASH_OE_N && FLASH_WE_N && !FLASH_DQ_OE && REQ_READY && !RSP_VALID)
		else $error("strobe or answer active after reset");
	chk_strobe_excl: assert property (
		!(!FLASH_OE_N && !FLASH_WE_N))
		else $error("read and write strobes low together");
	chk_write_drive: assert property (
		!FLASH_WE_N |-> FLASH_DQ_OE && !FLASH_CE_N)
		else $error("write strobe without select or data drive");
	chk_read_release: assert property (
		!FLASH_OE_N |-> !FLASH_DQ_OE)
		else $error("data driven during read strobe");
	chk_we_width: assert property (
		$fell(FLASH_WE_N) |-> !FLASH_WE_N [*5] ##1 FLASH_WE_N)
		else $error("write pulse length wrong");
	chk_word_sel: assert property (
		FLASH_WORD_N == WIDE_MODE)
		else $error("width select not following mode");
	chk_rsp_pulse: assert property (
		RSP_VALID |=> !RSP_VALID && REQ_READY)
		else $error("answer not a single pulse");
	chk_standby_ce: assert property (
		STANDBY_REQ && REQ_READY && !REQ_VALID |-> FLASH_CE_N)
		else $error("flash selected during standby");
endmodule // pmfc_ctrl_monitor
bind pmfc_ctrl pmfc_ctrl_monitor i_pmfc_ctrl_monitor (.REF_CLK(REF_CLK), .RESET(RESET),
	.REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
	.WIDE_MODE(WIDE_MODE), .STANDBY_REQ(STANDBY_REQ), .FLASH_CE_N(FLASH_CE_N),
	.FLASH_OE_N(FLASH_OE_N), .FLASH_WE_N(FLASH_WE_N), .FLASH_WORD_N(FLASH_WORD_N),
	.FLASH_DQ_OE(FLASH_DQ_OE));
`default_nettype wire

// *** tb/pmfc_flash_model.sv ***
// Behavioural page-mode flash: unlock sequences, status bits, one locked sector.
// Array folded onto 64 locations, four sectors of 16; pins come from pmfc_ctrl.
`timescale 1ns/1ps
`default_nettype none
module pmfc_flash_model
	import pmfc_pkg::*;
#(
	parameter logic [1:0] PROT_SECT = 2'h3
)
(
	// Pins from the controller
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              ce_n,
	input  wire logic              oe_n,
	input  wire logic              we_n,
	input  wire logic              word_n,
	input  wire logic [DATA_W-1:0] din,
	// Data lines and write count
	output logic [DATA_W-1:0]      dout,
	output int                     wr_count
);
	logic [DATA_W-1:0] mem [64];
	logic [DATA_W-1:0] tgt, v, r;
	logic [1:0]        step = 2'h0;
	logic              byp = 1'h0, prog = 1'h0, ers = 1'h0, tog = 1'h0, stat = 1'h0;
	int                busy = 0;
	initial
	begin
		foreach (mem[i])
			mem[i] = '1;
		wr_count = 0;
	end
	// Sample a little after the fall so pins launched on that edge have landed
	always @(negedge we_n)
	begin
		#1;
		wr_count++;
		v = word_n ? din : {16'hffff, din[15:0]};
		if (prog)
		begin
			prog = 1'h0;
			if (addr[5:4] != PROT_SECT)
				mem[addr[5:0]] &= v;
			tgt = v;
			busy = 3;
		end
		else if (byp && din[7:0] == CMD_PROGRAM)
			prog = 1'h1;
		else if (byp && din[7:0] == CMD_BYP_EXIT1)
			byp = 1'h0;
		else if (din[7:0] == CMD_RESET)
			step = 2'h0;
		else if (step == 2'h0 && din[7:0] == UNLOCK_D1 && addr == UNLOCK_A1)
			step = 2'h1;
		else if (step == 2'h1 && din[7:0] == UNLOCK_D2)
			step = 2'h2;
		else if (step == 2'h2)
		begin
			step = 2'h0;
			prog = (din[7:0] == CMD_PROGRAM);
			byp = (din[7:0] == CMD_BYPASS);
			if (ers)
			begin
				foreach (mem[i])
					if (i[5:4] != PROT_SECT && (din[7:0] == CMD_CHIP_ER || i[5:4] == addr[5:4]))
						mem[i] = '1;
				tgt = '1;
				busy = 4;
			end
			ers = (din[7:0] == CMD_ERASE);
		end
	end
	always @(negedge oe_n)
	begin
		#1;
		stat = (busy > 0);
		if (stat)
			busy--;
		if (stat)
			tog = ~tog;
	end
	// Released lines show the inverse so a stale value never passes
	always_comb
	begin
		r = stat ? {24'h0, ~tgt[7], tog, 6'h0} : mem[addr[5:0]];
		if (ce_n || oe_n)
			dout = ~r;
		else
			dout = word_n ? r : {~r[31:16], r[15:0]};
	end
endmodule // pmfc_flash_model
`default_nettype wire

// *** tb/test_pmfc_ctrl.sv ***
// Bench for pmfc_ctrl against the flash model: program, bypass, erase, locks, pages.
// Assumes pmfc_flash_model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module test_pmfc_ctrl;
	import pmfc_pkg::*;
	logic              ref_clk = 1'h0, reset = 1'h1, req_valid = 1'h0;
	logic              wide_mode = 1'h0, standby_req = 1'h0;
	pmfc_op_e          req_op = OP_READ;
	logic [ADDR_W-1:0] req_addr = '0, f_addr;
	logic [DATA_W-1:0] req_data = '0, rsp_data, dq_out, dq_in, f_dout;
	logic              req_ready, rsp_valid, rsp_error, byp, susp;
	logic              ce_n, oe_n, we_n, word_n, dq_oe;
	int                n_mismatch = 0, num_checks = 0, lat, w, wr_count;
	initial forever #4 ref_clk = ~ref_clk;
	pmfc_ctrl #(.POLL_LIMIT(16)) i_pmfc_ctrl (.REF_CLK(ref_clk), .RESET(reset),
		.REQ_VALID(req_valid), .REQ_OP(req_op), .REQ_ADDR(req_addr), .REQ_DATA(req_data),
		.WIDE_MODE(wide_mode), .STANDBY_REQ(standby_req), .REQ_READY(req_ready),
		.RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_ERROR(rsp_error),
		.BYPASS_ACTIVE(byp), .ERASE_SUSPENDED(susp), .FLASH_ADDR(f_addr),
		.FLASH_CE_N(ce_n), .FLASH_OE_N(oe_n), .FLASH_WE_N(we_n), .FLASH_WORD_N(word_n),
		.FLASH_DQ_OUT(dq_out), .FLASH_DQ_OE(dq_oe), .FLASH_DQ_IN(dq_in));
	pmfc_flash_model i_pmfc_flash_model (.addr(f_addr), .ce_n(ce_n), .oe_n(oe_n),
		.we_n(we_n), .word_n(word_n), .din(dq_in), .dout(f_dout), .wr_count(wr_count));
	assign dq_in = dq_oe ? dq_out : f_dout;
	task automatic chk_d(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_b(input logic got, input logic exp);
		chk_d({31'h0, got}, {31'h0, exp});
	endtask
	task automatic op(input pmfc_op_e o, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		@(negedge ref_clk);
		req_op = o;
		req_addr = a;
		req_data = d;
		req_valid = 1'h1;
		@(negedge ref_clk);
		req_valid = 1'h0;
		lat = 0;
		while (rsp_valid !== 1'h1 && lat < 3000)
		begin
			@(negedge ref_clk);
			lat++;
		end
		chk_b(rsp_valid, 1'h1);
	endtask
	task automatic t_reset();
		chk_b(req_ready & ce_n & oe_n & we_n & ~dq_oe, 1'h1);
		op(OP_READ, 21'h1fffff, '0);
		chk_d({11'h0, f_addr}, 32'(NARROW_WORDS - 1));
		chk_b(ce_n, 1'h0);
		standby_req = 1'h1;
		@(negedge ref_clk);
		chk_b(ce_n, 1'h1);
		standby_req = 1'h0;
	endtask
	task automatic t_program();
		w = wr_count;
		op(OP_PROGRAM, 21'h10, 32'h1234);
		chk_d(32'(wr_count - w), 32'h4);
		chk_b(rsp_error, 1'h0);
		op(OP_READ, 21'h10, '0);
		chk_d({16'h0, rsp_data[15:0]}, 32'h1234);
	endtask
	task automatic t_bypass();
		op(OP_BYPASS_ENTER, '0, '0);
		chk_b(byp, 1'h1);
		w = wr_count;
		op(OP_PROGRAM, 21'h25, 32'h5a5a);
		chk_d(32'(wr_count - w), 32'h2);
		op(OP_BYPASS_EXIT, '0, '0);
		chk_b(byp, 1'h0);
	endtask
	task automatic t_erase();
		op(OP_SECTOR_ERASE, 21'h10, '1);
		chk_b(rsp_error, 1'h0);
		op(OP_READ, 21'h10, '0);
		chk_d({16'h0, rsp_data[15:0]}, 32'hffff);
		op(OP_READ, 21'h25, '0);
		chk_d({16'h0, rsp_data[15:0]}, 32'h5a5a);
		op(OP_PROGRAM, 21'h30, 32'h0);
		chk_b(rsp_error, 1'h1);
		op(OP_READ, 21'h30, '0);
		chk_d({16'h0, rsp_data[15:0]}, 32'hffff);
	endtask
	// Mode only changes while idle; the pin must be stable across a transfer
	task automatic t_page();
		wide_mode = 1'h1;
		op(OP_READ, 21'h24, '0);
		w = lat;
		op(OP_READ, 21'h25, '0);
		chk_b(lat < w, 1'h1);
		chk_d(rsp_data, 32'hffff5a5a);
		// Standby drops chip select, so the open page must be fetched again
		standby_req = 1'h1;
		@(negedge ref_clk);
		standby_req = 1'h0;
		op(OP_READ, 21'h25, '0);
		chk_d(32'(lat), 32'(w));
		wide_mode = 1'h0;
	endtask
	task automatic t_misc();
		op(OP_SUSPEND, '0, '0);
		chk_b(susp, 1'h1);
		op(OP_RESUME, '0, '0);
		chk_b(susp, 1'h0);
		chk_b(rsp_error, 1'h0);
		op(OP_RESET, '0, '0);
		op(OP_CHIP_ERASE, '0, '1);
		chk_b(rsp_error, 1'h0);
		op(OP_READ, 21'h25, '0);
		chk_d({16'h0, rsp_data[15:0]}, 32'hffff);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(negedge ref_clk);
		reset = 1'h0;
		t_reset();
		t_program();
		t_bypass();
		t_erase();
		t_page();
		t_misc();
		test_done();
	end
	// Whole run needs under a thousand cycles; this leaves ample margin
	initial
	begin
		repeat (40000) @(posedge ref_clk);
		n_mismatch++;
		test_done();
	end
endmodule // test_pmfc_ctrl
`default_nettype wire
